// ---- design/pced_defines.vh ----
/*
 * Register offsets, field positions, reset values and widths for the
 * pin change edge interrupt block.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
`ifndef PCED_DEFINES_VH
`define PCED_DEFINES_VH

`define PCED_NPINS          6
`define PCED_ADDR_W         5

`define PCED_OFF_RISE       5'h00
`define PCED_OFF_FALL       5'h04
`define PCED_OFF_FLAGS      5'h08
`define PCED_OFF_INTCTL     5'h0C
`define PCED_OFF_IRQ_STAT   5'h10
`define PCED_OFF_IRQ_MASK   5'h14

`define PCED_INTCTL_MIE     0
`define PCED_INTCTL_SUM     1
`define PCED_INTCTL_WAKE    2

`define PCED_EVT_EDGE       0
`define PCED_EVT_WAKE       1
`define PCED_EVT_W          2

`define PCED_RST_EN         6'h00
`define PCED_RST_FLAGS      6'h00
`define PCED_RST_MASK       2'h0

`define PCED_RESP_OKAY      2'h0
`define PCED_RESP_SLVERR    2'h2

`endif

// ---- design/pced_top.v ----
/*
 * Pin change edge interrupt block: per-pin rising and falling edge
 * detection, sticky change flags, summary flag, interrupt and wake.
 * Assumes pins synchronous to aclk and an AXI4-Lite master on the bus.
 */
// The address map and the AXI4-Lite slave port are this design's own decisions.
// What this block does
// - Each pin has rising and falling detectors; rise-enable bit arms rising.
// - Fall-enable bit arms falling detection; clearing it disables falling detection.
// - Both enable bits set detect rising and falling edges together.
// - Flag sets on enabled rising edge or enabled falling edge of the pin.
// - Flagged edge raises the interrupt while master enable is set, or through its status bit when unmasked.
// - Summary flag is high whenever any per-pin change flag is set.
// - Writing zero clears a flag; a new edge during the write wins.
// - With master enable set, any set change flag (from an enabled edge) wakes the device from sleep.
// - Edges seen during sleep reach the flag register before wake-up completes.
// - Only bits five to zero exist; bits seven and six read zero.
// - Flags are software read/write and hardware set; all reset to zero.
// - Without master enable, detection and flags continue; interrupt only from unmasked status bits.
`timescale 1ns/10ps
`include "pced_defines.vh"

module pced_top (
  // Clock, reset, enable
  input  wire                      aclk,
  input  wire                      aresetn,
  input  wire                      clk_en,
  // Port pins and sleep state
  input  wire [`PCED_NPINS-1:0]    port_pin,
  input  wire                      sleep_mode,
  // AXI4-Lite write address
  input  wire [`PCED_ADDR_W-1:0]   s_axi_awaddr,
  input  wire                      s_axi_awvalid,
  output reg                       s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]               s_axi_wdata,
  input  wire [3:0]                s_axi_wstrb,
  input  wire                      s_axi_wvalid,
  output reg                       s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]                s_axi_bresp,
  output reg                       s_axi_bvalid,
  input  wire                      s_axi_bready,
  // AXI4-Lite read address
  input  wire [`PCED_ADDR_W-1:0]   s_axi_araddr,
  input  wire                      s_axi_arvalid,
  output reg                       s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]               s_axi_rdata,
  output reg  [1:0]                s_axi_rresp,
  output reg                       s_axi_rvalid,
  input  wire                      s_axi_rready,
  // Interrupt and wake
  output reg                       change_irq,
  output reg                       wake_req
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [`PCED_NPINS-1:0]  pin_sync_r;
  reg  [`PCED_NPINS-1:0]  pin_prev_r;
  reg                     pin_valid_r;
  reg  [`PCED_NPINS-1:0]  rise_edge_enable_r;
  reg  [`PCED_NPINS-1:0]  fall_edge_enable_r;
  reg  [`PCED_NPINS-1:0]  pin_change_flags_r;
  reg  [`PCED_NPINS-1:0]  pin_change_flags_nxt;
  reg                     change_int_master_enable_r;
  reg  [`PCED_EVT_W-1:0]  irq_stat_r;
  reg  [`PCED_EVT_W-1:0]  irq_stat_nxt;
  reg  [`PCED_EVT_W-1:0]  irq_mask_r;
  reg  [`PCED_ADDR_W-1:0] awaddr_r;
  reg                     aw_held_r;
  reg  [31:0]             wdata_r;
  reg  [3:0]              wstrb_r;
  reg                     w_held_r;

  wire [`PCED_NPINS-1:0]  rise_seen;
  wire [`PCED_NPINS-1:0]  fall_seen;
  wire [`PCED_NPINS-1:0]  edge_hit;
  wire                    change_summary_flag;
  wire                    wake_evt;
  wire                    wr_go;
  wire                    rd_go;
  wire [`PCED_ADDR_W-1:0] wr_addr;
  wire [31:0]             wr_data;
  wire                    wr_lane0;
  reg  [31:0]             rd_word;
  reg                     rd_ok;
  reg                     wr_ok;

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  // sample and compare
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_sync_r  <= `PCED_RST_FLAGS;
      pin_prev_r  <= `PCED_RST_FLAGS;
      pin_valid_r <= 1'b0;
    end else if (clk_en) begin
      pin_sync_r  <= port_pin;
      pin_prev_r  <= pin_sync_r;
      pin_valid_r <= 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `PCED_NPINS; gi = gi + 1) begin : g_pin
      assign rise_seen[gi] = pin_valid_r & pin_sync_r[gi] & ~pin_prev_r[gi];
      assign fall_seen[gi] = pin_valid_r & ~pin_sync_r[gi] & pin_prev_r[gi];
      assign edge_hit[gi] = (rise_seen[gi] & rise_edge_enable_r[gi]) |
                            (fall_seen[gi] & fall_edge_enable_r[gi]);
    end
  endgenerate

  assign change_summary_flag = |pin_change_flags_r;
  assign wake_evt = sleep_mode & change_int_master_enable_r & (|edge_hit);

  // ----------------------------------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------------------------------
  assign wr_go    = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign rd_go    = s_axi_arvalid & s_axi_arready;
  assign wr_addr  = awaddr_r;
  assign wr_data  = wdata_r;
  assign wr_lane0 = wstrb_r[0];

  always @* begin
    wr_ok = 1'b1;
    case (wr_addr)
      `PCED_OFF_RISE,
      `PCED_OFF_FALL,
      `PCED_OFF_FLAGS,
      `PCED_OFF_INTCTL,
      `PCED_OFF_IRQ_STAT,
      `PCED_OFF_IRQ_MASK: wr_ok = 1'b1;
      default:            wr_ok = 1'b0;
    endcase
  end

  always @* begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      `PCED_OFF_RISE:     rd_word[`PCED_NPINS-1:0] = rise_edge_enable_r;
      `PCED_OFF_FALL:     rd_word[`PCED_NPINS-1:0] = fall_edge_enable_r;
      `PCED_OFF_FLAGS:    rd_word[`PCED_NPINS-1:0] = pin_change_flags_r;
      `PCED_OFF_INTCTL: begin
        rd_word[`PCED_INTCTL_MIE]  = change_int_master_enable_r;
        rd_word[`PCED_INTCTL_SUM]  = change_summary_flag;
        rd_word[`PCED_INTCTL_WAKE] = wake_req;
      end
      `PCED_OFF_IRQ_STAT: rd_word[`PCED_EVT_W-1:0] = irq_stat_r;
      `PCED_OFF_IRQ_MASK: rd_word[`PCED_EVT_W-1:0] = irq_mask_r;
      default:            rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PCED_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `PCED_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 5'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
    end else if (clk_en) begin
      s_axi_awready <= ~aw_held_r & ~s_axi_awready & s_axi_awvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      s_axi_wready <= ~w_held_r & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `PCED_RESP_OKAY : `PCED_RESP_SLVERR;
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? `PCED_RESP_OKAY : `PCED_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags, enables and interrupt status
  // ----------------------------------------------------------------
  always @* begin
    pin_change_flags_nxt = pin_change_flags_r;
    if (wr_go & wr_lane0 & (wr_addr == `PCED_OFF_FLAGS))
      pin_change_flags_nxt = wr_data[`PCED_NPINS-1:0];
    pin_change_flags_nxt = pin_change_flags_nxt | edge_hit;
  end

  always @* begin
    irq_stat_nxt = irq_stat_r;
    if (rd_go & (s_axi_araddr == `PCED_OFF_IRQ_STAT))
      irq_stat_nxt = {`PCED_EVT_W{1'b0}};
    irq_stat_nxt[`PCED_EVT_EDGE] = irq_stat_nxt[`PCED_EVT_EDGE] | (|edge_hit);
    irq_stat_nxt[`PCED_EVT_WAKE] = irq_stat_nxt[`PCED_EVT_WAKE] | wake_evt;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rise_edge_enable_r         <= `PCED_RST_EN;
      fall_edge_enable_r         <= `PCED_RST_EN;
      pin_change_flags_r         <= `PCED_RST_FLAGS;
      change_int_master_enable_r <= 1'b0;
      irq_stat_r                 <= `PCED_RST_MASK;
      irq_mask_r                 <= `PCED_RST_MASK;
      change_irq                 <= 1'b0;
      wake_req                   <= 1'b0;
    end else if (clk_en) begin
      pin_change_flags_r <= pin_change_flags_nxt;
      irq_stat_r         <= irq_stat_nxt;
      if (wr_go & wr_lane0) begin
        case (wr_addr)
          `PCED_OFF_RISE:     rise_edge_enable_r <= wr_data[`PCED_NPINS-1:0];
          `PCED_OFF_FALL:     fall_edge_enable_r <= wr_data[`PCED_NPINS-1:0];
          `PCED_OFF_INTCTL:   change_int_master_enable_r <= wr_data[`PCED_INTCTL_MIE];
          `PCED_OFF_IRQ_MASK: irq_mask_r <= wr_data[`PCED_EVT_W-1:0];
          default: ;
        endcase
      end
      change_irq <= (change_int_master_enable_r & (|pin_change_flags_nxt)) |
                    (|(irq_stat_nxt & irq_mask_r));
      wake_req <= sleep_mode & change_int_master_enable_r & (|pin_change_flags_nxt);
    end
  end

endmodule

// ---- tb/pced_top_props.sv ----
/* Port checker for the pin change edge block.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/10ps
`include "pced_defines.vh"
module pced_props (
  // Clock, reset and sleep state
  input wire        aclk,
  input wire        aresetn,
  input wire        sleep_mode,
  // Bus handshakes
  input wire        s_axi_awready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // Interrupt and wake
  input wire        change_irq,
  input wire        wake_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_quiet: assert property ($rose(aresetn) |-> !change_irq && !wake_req)
    else $error("outputs not quiet after reset");
  a_wake_sleep: assert property (wake_req |-> $past(sleep_mode))
    else $error("wake without sleep");
  a_wake_irq: assert property (wake_req |-> change_irq)
    else $error("wake without interrupt");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0)
    else $error("upper read bits set");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp == `PCED_RESP_OKAY
    || s_axi_bresp == `PCED_RESP_SLVERR) else $error("bad write response");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("address ready held");
  c_irq: cover property (change_irq);
  c_wake: cover property (wake_req);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `PCED_RESP_SLVERR);
endmodule
bind pced_top pced_props pced_props_inst (.aclk, .aresetn, .sleep_mode, .s_axi_awready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .change_irq, .wake_req);

// ---- tb/pced_pin_model.sv ----
/* Far-side pin driver for the edge block.
   Assumes levels change just after aclk edges. */
`timescale 1ns/10ps
module pced_pin_model (
  // Requested and driven levels
  input  wire [5:0] level,
  output wire [5:0] port_pin
);
  // Push-pull pins, never released
  assign port_pin = level;
endmodule

// ---- tb/tb_pin_change_edge_interrupt.sv ----
/* Self-checking bench for the pin change edge block.
   Assumes the pin model and the bound checker compile first. */
`timescale 1ns/10ps
`include "pced_defines.vh"
`define CHK(n,e,g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_pin_change_edge_interrupt;
  logic        aclk = 0, aresetn = 0, sleep_mode = 0, mie, xp;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [4:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdat, rng = 32'h00009F04;
  logic [5:0]  pin_lvl = 0, ef, er, en, old, t;
  logic [1:0]  resp;
  wire         awready, wready, bvalid, arready, rvalid, change_irq, wake_req;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [5:0]  port_pin;
  int          bad_count = 0, check_count = 0, cyc = 0, bcyc, t0;
  pced_pin_model pced_pin_model_inst (.level(pin_lvl), .port_pin(port_pin));
  pced_top pced_top_inst (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
    .port_pin(port_pin), .sleep_mode(sleep_mode), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .change_irq(change_irq), .wake_req(wake_req));
  initial forever #4 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic [5:0] hit(input logic [5:0] o, n, r, f);
    return (r & ~o & n) | (f & o & ~n);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0; resp = bresp; bcyc = cyc; tick(1);
  endtask
  task automatic rd(input logic [4:0] a);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0; rdat = rdata; resp = rresp; tick(1);
  endtask
  task automatic toggle();
    old = ~old;
    pin_lvl <= old;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    tick(20000);
    bad_count++;
    give_verdict();
  end
  initial begin
    tick(12); aresetn <= 1'b1; tick(1);
    for (int a = 0; a < 8; a++) begin
      rd(5'(a * 4));
      `CHK("reset value", 32'h0, rdat)
      `CHK("read resp", (a < 6) ? `PCED_RESP_OKAY : `PCED_RESP_SLVERR, resp)
    end
    wr(5'h1C, 32'hFFFFFFFF);
    `CHK("write resp", `PCED_RESP_SLVERR, resp)
    for (int a = 0; a < 2; a++) begin
      wr(5'(a * 4), 32'hFFFFFFFF); rd(5'(a * 4));
      `CHK("enable width", 32'h3F, rdat)
    end
    $display("test registers done");
    ef = 0; old = 0;
    for (int i = 0; i < 40; i++) begin
      er = 6'(rnd()); en = 6'(rnd()); mie = rnd() & 1; t = 6'(rnd());
      wr(`PCED_OFF_RISE, {26'h0, er}); wr(`PCED_OFF_FALL, {26'h0, en});
      wr(`PCED_OFF_INTCTL, {31'h0, mie});
      pin_lvl <= t; ef |= hit(old, t, er, en); old = t; tick(4);
      `CHK("irq level", mie & (|ef), change_irq)
      rd(`PCED_OFF_INTCTL);
      `CHK("summary", {|ef, mie}, rdat[1:0])
      rd(`PCED_OFF_FLAGS);
      `CHK("flags", {26'h0, ef}, rdat)
      if (i % 2) begin wr(`PCED_OFF_FLAGS, rdat & ~{26'h0, ef}); ef = 0; end
    end
    $display("test random edges done");
    wr(`PCED_OFF_RISE, 32'h3F); wr(`PCED_OFF_FALL, 32'h3F);
    for (int k = 0; k < 6; k++) begin
      wr(`PCED_OFF_FLAGS, 32'h0); t0 = cyc;
      fork
        begin tick(3); wr(`PCED_OFF_FLAGS, 32'h0); end
        begin tick(k); toggle(); end
      join
      xp = (t0 + k + 3 >= bcyc); tick(4); rd(`PCED_OFF_FLAGS);
      `CHK("clear race", xp ? 32'h3F : 32'h0, rdat)
    end
    $display("test clear race done");
    wr(`PCED_OFF_FLAGS, 32'h0); wr(`PCED_OFF_INTCTL, 32'h1);
    sleep_mode <= 1'b1; toggle(); tick(4);
    `CHK("wake", 1'b1, wake_req)
    sleep_mode <= 1'b0; rd(`PCED_OFF_FLAGS);
    `CHK("flags at wake", 32'h3F, rdat)
    wr(`PCED_OFF_FLAGS, 32'h0); wr(`PCED_OFF_INTCTL, 32'h0);
    sleep_mode <= 1'b1; toggle(); tick(4);
    `CHK("no wake", 1'b0, wake_req)
    `CHK("no irq", 1'b0, change_irq)
    sleep_mode <= 1'b0; rd(`PCED_OFF_FLAGS);
    `CHK("flags no mie", 32'h3F, rdat)
    $display("test sleep done");
    rd(`PCED_OFF_IRQ_STAT);
    `CHK("status", 32'h3, rdat)
    rd(`PCED_OFF_IRQ_STAT);
    `CHK("status cleared", 32'h0, rdat)
    wr(`PCED_OFF_IRQ_MASK, 32'h1); toggle(); tick(4);
    `CHK("masked irq", 1'b1, change_irq)
    rd(`PCED_OFF_IRQ_STAT); tick(2);
    `CHK("irq cleared", 1'b0, change_irq)
    $display("test status done");
    give_verdict();
  end
endmodule
